//--- rtl/mswcl_monitor.sv
`timescale 1ns/1ps
module mswcl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic do_push;
  logic do_pop;
  assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign do_push = i_in_valid && o_in_ready;
  assign do_pop = o_out_valid && i_out_ready;
  always_ff @(posedge i_core_clk) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
      if (do_pop) rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
      count_reg <= (AW+1)'(count_reg + do_push - do_pop);
    end
  end
endmodule // mswcl_fifo

// What this block does
// - Every received byte is echoed straight back on the monitor line.
// - Command results are queued after the echo of the command's last byte.
// - Start bit plus nine low bits with no stop bit is a break.
// - After a received break, release line two bit times, then echo the break.
// - Six commands: read, write, indexed read, indexed write, stack read, run.
// - Indexed read 1A returns next two bytes and advances the address.
// - Kept address lets indexed accesses walk the full 64-Kbyte space.
// - Run opcode 28 has no operand, no data, triggers return from interrupt.
// - Without PLL, divide pin high at reset gives 4800, low gives 9600 baud.
// - With PLL, multiplier 1..6 gives 4800 to 28800 baud.
// - Transmit and receive share one baud rate between 4800 and 28800.
// - On monitor entry, send a break of ten low bits.
// - Single wired-OR line, each party only pulls low or releases.
module mswcl_monitor
  import mswcl_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Monitor line, open drain
  input wire logic i_monitor_line_pin,
  output logic o_monitor_line_pin,
  output logic o_monitor_line_pin_oe,
  // Baud straps
  input wire logic i_clock_divide_select_pin,
  input wire logic i_pll_drives_clock_generator_output,
  input wire logic [3:0] i_pll_multiplier_field,
  // Core side
  input wire logic i_monitor_entry,
  input wire logic [15:0] i_stack_ptr,
  output logic o_return_from_interrupt_instr,
  // Memory port
  output logic [15:0] o_mem_addr,
  output logic o_mem_rd,
  input wire logic [7:0] i_mem_rdata,
  output logic o_mem_wr,
  output logic [7:0] o_mem_wdata
);
  import mswcl_pkg::*;
  logic strap_done_reg;
  logic [BIT_CYC_W-1:0] bit_cyc_reg;
  mswcl_rx_e rx_state_reg;
  logic [BIT_CYC_W-1:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  logic [7:0] rx_sh_reg;
  logic rx_vld_reg;
  logic rx_brk_reg;
  logic [7:0] rx_data_reg;
  logic rx_take;
  mswcl_tx_e tx_state_reg;
  logic [BIT_CYC_W-1:0] tx_cnt_reg;
  logic [3:0] tx_bits_reg;
  logic [9:0] tx_sh_reg;
  logic q_in_ready;
  logic q_out_valid;
  logic [ENT_W-1:0] q_out_data;
  logic q_pop;
  mswcl_cmd_e st_reg;
  logic [7:0] cmd_reg;
  logic [15:0] addr_reg;
  logic entry_pend_reg;
  logic run_reg;
  logic mem_wr_reg;
  logic [7:0] wdata_reg;
  logic push;
  logic [ENT_W-1:0] push_data;

  // Baud capture one cycle after reset release
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      strap_done_reg <= 1'b0;
      bit_cyc_reg <= BIT_CYC_X1;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      if (i_pll_drives_clock_generator_output) begin
        unique case (i_pll_multiplier_field)
          4'h2: bit_cyc_reg <= BIT_CYC_X2;
          4'h3: bit_cyc_reg <= BIT_CYC_X3;
          4'h4: bit_cyc_reg <= BIT_CYC_X4;
          4'h5: bit_cyc_reg <= BIT_CYC_X5;
          4'h6: bit_cyc_reg <= BIT_CYC_X6;
          default: bit_cyc_reg <= BIT_CYC_X1;
        endcase
      end else begin
        bit_cyc_reg <= i_clock_divide_select_pin ? BIT_CYC_X1 : BIT_CYC_X2;
      end
    end
  end

  // Receiver, idle while we transmit
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= '0;
      rx_bit_reg <= '0;
      rx_sh_reg <= '0;
      rx_vld_reg <= 1'b0;
      rx_brk_reg <= 1'b0;
      rx_data_reg <= '0;
    end else begin
      if (rx_take) begin
        rx_vld_reg <= 1'b0;
        rx_brk_reg <= 1'b0;
      end
      unique case (rx_state_reg)
        RX_IDLE: if (strap_done_reg && tx_state_reg == TX_IDLE && !i_monitor_line_pin) begin
          rx_state_reg <= RX_START;
          rx_cnt_reg <= bit_cyc_reg >> 1;
        end
        RX_START: if (rx_cnt_reg == '0) begin
          rx_state_reg <= i_monitor_line_pin ? RX_IDLE : RX_BITS;
          rx_cnt_reg <= BIT_CYC_W'(bit_cyc_reg - 1'b1);
          rx_bit_reg <= '0;
        end else begin
          rx_cnt_reg <= BIT_CYC_W'(rx_cnt_reg - 1'b1);
        end
        RX_BITS: if (rx_cnt_reg != '0) begin
          rx_cnt_reg <= BIT_CYC_W'(rx_cnt_reg - 1'b1);
        end else if (rx_bit_reg == DATA_BITS) begin
          rx_state_reg <= RX_HIGH;
          if (i_monitor_line_pin) begin
            rx_vld_reg <= 1'b1;
            rx_data_reg <= rx_sh_reg;
          end else if (rx_sh_reg == 8'h00) begin
            rx_brk_reg <= 1'b1;
          end
        end else begin
          rx_sh_reg <= {i_monitor_line_pin, rx_sh_reg[7:1]};
          rx_bit_reg <= 4'(rx_bit_reg + 1'b1);
          rx_cnt_reg <= BIT_CYC_W'(bit_cyc_reg - 1'b1);
        end
        RX_HIGH: if (i_monitor_line_pin) rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  mswcl_fifo #(.WIDTH(ENT_W), .DEPTH(FIFO_DEPTH)) u_txq (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_in_valid(push),
    .i_in_data(push_data),
    .o_in_ready(q_in_ready),
    .o_out_valid(q_out_valid),
    .o_out_data(q_out_data),
    .i_out_ready(q_pop)
  );

  // Transmitter
  assign q_pop = (tx_state_reg == TX_IDLE) && q_out_valid;
  assign o_monitor_line_pin = 1'b0;
  assign o_monitor_line_pin_oe = (tx_state_reg == TX_SHIFT) && !tx_sh_reg[0];
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg <= '0;
      tx_bits_reg <= '0;
      tx_sh_reg <= '1;
    end else begin
      unique case (tx_state_reg)
        TX_IDLE: if (q_pop) begin
          tx_cnt_reg <= BIT_CYC_W'(bit_cyc_reg - 1'b1);
          if (q_out_data[ENT_GAP]) begin
            tx_state_reg <= TX_GAP;
            tx_bits_reg <= GAP_BITS_M1;
            tx_sh_reg <= '0;
          end else begin
            tx_state_reg <= TX_SHIFT;
            tx_bits_reg <= '0;
            tx_sh_reg <= q_out_data[ENT_BRK] ? 10'h000 : {1'b1, q_out_data[7:0], 1'b0};
          end
        end
        TX_GAP: if (tx_cnt_reg != '0) begin
          tx_cnt_reg <= BIT_CYC_W'(tx_cnt_reg - 1'b1);
        end else begin
          tx_cnt_reg <= BIT_CYC_W'(bit_cyc_reg - 1'b1);
          if (tx_bits_reg == '0) tx_state_reg <= TX_SHIFT;
          else tx_bits_reg <= 4'(tx_bits_reg - 1'b1);
        end
        TX_SHIFT: if (tx_cnt_reg != '0) begin
          tx_cnt_reg <= BIT_CYC_W'(tx_cnt_reg - 1'b1);
        end else if (tx_bits_reg == FRAME_LAST) begin
          tx_state_reg <= TX_IDLE;
          tx_sh_reg <= '1;
        end else begin
          tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
          tx_bits_reg <= 4'(tx_bits_reg + 1'b1);
          tx_cnt_reg <= BIT_CYC_W'(bit_cyc_reg - 1'b1);
        end
      endcase
    end
  end

  // Queue feed: echo first, then results
  always_comb begin
    push = 1'b0;
    push_data = '0;
    rx_take = 1'b0;
    o_mem_rd = 1'b0;
    unique case (st_reg)
      S_RD1, S_RD2: begin
        o_mem_rd = q_in_ready;
        push = 1'b1;
        push_data = {2'b00, i_mem_rdata};
      end
      S_SP1: begin
        push = 1'b1;
        push_data = {2'b00, i_stack_ptr[15:8]};
      end
      S_SP2: begin
        push = 1'b1;
        push_data = {2'b00, i_stack_ptr[7:0]};
      end
      default: begin
        if (rx_brk_reg) begin
          push = 1'b1;
          push_data = ENT_BRK_ECHO;
          rx_take = q_in_ready;
        end else if (rx_vld_reg) begin
          push = 1'b1;
          push_data = {2'b00, rx_data_reg};
          rx_take = q_in_ready;
        end else if (entry_pend_reg && st_reg == S_OP) begin
          push = 1'b1;
          push_data = ENT_BRK_ENTRY;
        end
      end
    endcase
  end

  // Command sequencer
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      st_reg <= S_OP;
      cmd_reg <= '0;
      addr_reg <= '0;
      run_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      wdata_reg <= '0;
    end else begin
      run_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      if (q_in_ready) begin
        if (rx_take && rx_brk_reg) begin
          st_reg <= S_OP;
        end else if (rx_take) begin
          unique case (st_reg)
            S_OP: begin
              cmd_reg <= rx_data_reg;
              unique case (rx_data_reg)
                OP_READ, OP_WRITE: st_reg <= S_AH;
                OP_INDEXED_READ: begin
                  addr_reg <= 16'(addr_reg + 1'b1);
                  st_reg <= S_RD1;
                end
                OP_INDEXED_WRITE: begin
                  addr_reg <= 16'(addr_reg + 1'b1);
                  st_reg <= S_WD;
                end
                OP_STACK_READ: st_reg <= S_SP1;
                OP_RUN: run_reg <= 1'b1;
                default: st_reg <= S_OP;
              endcase
            end
            S_AH: begin
              addr_reg[15:8] <= rx_data_reg;
              st_reg <= S_AL;
            end
            S_AL: begin
              addr_reg[7:0] <= rx_data_reg;
              st_reg <= (cmd_reg == OP_READ) ? S_RD1 : S_WD;
            end
            default: begin
              wdata_reg <= rx_data_reg;
              mem_wr_reg <= 1'b1;
              st_reg <= S_OP;
            end
          endcase
        end else begin
          unique case (st_reg)
            S_RD1: if (cmd_reg == OP_INDEXED_READ) begin
              addr_reg <= 16'(addr_reg + 1'b1);
              st_reg <= S_RD2;
            end else begin
              st_reg <= S_OP;
            end
            S_SP1: st_reg <= S_SP2;
            S_RD2, S_SP2: st_reg <= S_OP;
            default: st_reg <= st_reg;
          endcase
        end
      end
    end
  end

  // Entry break request, set wins over clear
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) entry_pend_reg <= 1'b0;
    else if (i_monitor_entry) entry_pend_reg <= 1'b1;
    else if (push && q_in_ready && push_data == ENT_BRK_ENTRY) entry_pend_reg <= 1'b0;
  end

  assign o_mem_addr = addr_reg;
  assign o_mem_wr = mem_wr_reg;
  assign o_mem_wdata = wdata_reg;
  assign o_return_from_interrupt_instr = run_reg;

  chk_echo_byte: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (rx_vld_reg && !rx_brk_reg && q_in_ready && (st_reg inside {S_OP, S_AH, S_AL, S_WD}))
    |=> u_txq.mem_reg[$past(u_txq.wr_ptr_reg)] == {2'b00, $past(rx_data_reg)})
    else $error("received byte not queued as echo");
  chk_result_order: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (st_reg == S_AL && rx_take && !rx_brk_reg && cmd_reg == OP_READ)
    |=> st_reg == S_RD1 && !rx_vld_reg)
    else $error("read result not after address echo");
  chk_break_seen: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (rx_state_reg == RX_BITS && rx_cnt_reg == '0 && rx_bit_reg == DATA_BITS
     && !i_monitor_line_pin && rx_sh_reg == 8'h00) |=> rx_brk_reg)
    else $error("break not recognised");
  chk_break_gap: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (tx_state_reg == TX_IDLE && q_pop && q_out_data == ENT_BRK_ECHO)
    |=> (tx_state_reg == TX_GAP && !o_monitor_line_pin_oe) [*2])
    else $error("break echo without high gap");
  chk_indexed_step: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (st_reg == S_OP && rx_take && !rx_brk_reg && rx_data_reg == OP_INDEXED_READ)
    |=> st_reg == S_RD1 && addr_reg == 16'($past(addr_reg) + 1'b1))
    else $error("indexed read address not advanced");
  chk_run_pulse: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (st_reg == S_OP && rx_take && !rx_brk_reg && rx_data_reg == OP_RUN)
    |=> o_return_from_interrupt_instr ##1 !o_return_from_interrupt_instr)
    else $error("run opcode did not pulse");
  chk_baud_div: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (!strap_done_reg && !i_pll_drives_clock_generator_output && !i_clock_divide_select_pin)
    |=> bit_cyc_reg == BIT_CYC_X2)
    else $error("wrong baud for low divide pin");
  chk_line_idle: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (tx_state_reg != TX_SHIFT) |-> !o_monitor_line_pin_oe && !o_monitor_line_pin)
    else $error("line driven outside a frame");
  chk_start_low: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (tx_state_reg != TX_SHIFT) ##1 (tx_state_reg == TX_SHIFT) |-> o_monitor_line_pin_oe)
    else $error("frame without low start bit");
  chk_entry_brk: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (entry_pend_reg && st_reg == S_OP && !rx_vld_reg && !rx_brk_reg && q_in_ready)
    |-> push && push_data == ENT_BRK_ENTRY)
    else $error("entry break not queued");

  cov_indexed_read: cover property (@(posedge i_core_clk) st_reg == S_RD1 ##1 st_reg == S_RD2);
  cov_break: cover property (@(posedge i_core_clk) tx_state_reg == TX_GAP);
  cov_q_full: cover property (@(posedge i_core_clk) !q_in_ready);
endmodule // mswcl_monitor

//--- rtl/mswcl_pkg.sv
package mswcl_pkg;
  // Clock and link timing
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_BASE = 4800;
  localparam int BIT_CYC_W = 12;
  localparam logic [BIT_CYC_W-1:0] BIT_CYC_X1 = BIT_CYC_W'(CLK_HZ / (BAUD_BASE * 1));
  localparam logic [BIT_CYC_W-1:0] BIT_CYC_X2 = BIT_CYC_W'(CLK_HZ / (BAUD_BASE * 2));
  localparam logic [BIT_CYC_W-1:0] BIT_CYC_X3 = BIT_CYC_W'(CLK_HZ / (BAUD_BASE * 3));
  localparam logic [BIT_CYC_W-1:0] BIT_CYC_X4 = BIT_CYC_W'(CLK_HZ / (BAUD_BASE * 4));
  localparam logic [BIT_CYC_W-1:0] BIT_CYC_X5 = BIT_CYC_W'(CLK_HZ / (BAUD_BASE * 5));
  localparam logic [BIT_CYC_W-1:0] BIT_CYC_X6 = BIT_CYC_W'(CLK_HZ / (BAUD_BASE * 6));
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] FRAME_LAST = 4'h9;
  localparam logic [3:0] GAP_BITS_M1 = 4'h1;
  // Command opcodes
  localparam logic [7:0] OP_READ = 8'h11;
  localparam logic [7:0] OP_WRITE = 8'h12;
  localparam logic [7:0] OP_INDEXED_READ = 8'h1A;
  localparam logic [7:0] OP_INDEXED_WRITE = 8'h14;
  localparam logic [7:0] OP_STACK_READ = 8'h15;
  localparam logic [7:0] OP_RUN = 8'h28;
  // Transmit queue entry: {gap_first, is_break, data}
  localparam int ENT_W = 10;
  localparam int ENT_GAP = 9;
  localparam int ENT_BRK = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [ENT_W-1:0] ENT_BRK_ECHO = 10'h300;
  localparam logic [ENT_W-1:0] ENT_BRK_ENTRY = 10'h100;
  typedef enum logic [2:0] {
    S_OP = 3'b000, S_AH = 3'b001, S_AL = 3'b011, S_WD = 3'b010,
    S_RD1 = 3'b110, S_RD2 = 3'b111, S_SP1 = 3'b101, S_SP2 = 3'b100
  } mswcl_cmd_e;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b11, RX_HIGH = 2'b10
  } mswcl_rx_e;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_GAP = 2'b01, TX_SHIFT = 2'b11
  } mswcl_tx_e;
endpackage

//--- tb/mswcl_host.sv
`timescale 1ns/1ps
module mswcl_host (
  // Clock and wire
  input wire logic i_core_clk,
  input wire logic i_line,
  // Open-drain pull
  output logic o_pull_low
);
  int bit_cyc = 347;
  initial o_pull_low = 1'b0;
  task automatic hold_bits(input logic low, input int n);
    o_pull_low <= low;
    repeat (n * bit_cyc) @(posedge i_core_clk);
  endtask
  // Start low, data LSB first, released stop
  task automatic send_byte(input logic [7:0] d);
    hold_bits(1'b1, 1);
    for (int i = 0; i < 8; i++) begin
      hold_bits(~d[i], 1);
    end
    o_pull_low <= 1'b0;
    repeat (bit_cyc / 4) @(posedge i_core_clk);
  endtask
  task automatic send_break();
    hold_bits(1'b1, 10);
    o_pull_low <= 1'b0;
    @(posedge i_core_clk);
  endtask
  // Frame bits: [0] start, [8:1] data, [9] stop
  task automatic recv_frame(output logic [9:0] f);
    int n;
    n = 0;
    while (i_line !== 1'b0 && n < 40 * bit_cyc) begin
      @(posedge i_core_clk);
      n++;
    end
    for (int i = 0; i < 10; i++) begin
      repeat (i == 0 ? bit_cyc / 2 : bit_cyc) @(posedge i_core_clk);
      f[i] = i_line;
    end
    repeat (bit_cyc / 2 - 2) @(posedge i_core_clk);
  endtask
endmodule // mswcl_host

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import mswcl_pkg::*;
  localparam logic [15:0] SP_VAL = 16'hC3A5;
  localparam int FAST = int'(BIT_CYC_X6);
  localparam int SLOW = int'(BIT_CYC_X2);
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic div_pin = 1'b1;
  logic pll_on = 1'b1;
  logic [3:0] pll_mul = 4'h6;
  logic entry = 1'b0;
  logic dev_oe, dev_out, run_pulse, mem_rd, mem_wr, host_low;
  logic [15:0] mem_addr;
  logic [15:0] wr_addr = 16'h0000;
  logic [7:0] mem_wdata, mem_rdata;
  logic [7:0] wr_data = 8'h00;
  wire line = ((dev_oe && !dev_out) || host_low) ? 1'b0 : 1'b1;
  int errors = 0;
  int check_count = 0;
  int run_count = 0;
  int rd_count = 0;
  always #50 core_clk = ~core_clk;
  assign mem_rdata = mem_addr[15:8] ^ mem_addr[7:0] ^ 8'h5A;
  always @(posedge core_clk) begin
    if (mem_wr === 1'b1) begin
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
    end
    if (run_pulse === 1'b1) begin
      run_count++;
    end
    if (mem_rd === 1'b1) begin
      rd_count++;
    end
  end
  mswcl_monitor u_mswcl_monitor (
    .i_core_clk(core_clk),
    .i_resetn(resetn),
    .i_monitor_line_pin(line),
    .o_monitor_line_pin(dev_out),
    .o_monitor_line_pin_oe(dev_oe),
    .i_clock_divide_select_pin(div_pin),
    .i_pll_drives_clock_generator_output(pll_on),
    .i_pll_multiplier_field(pll_mul),
    .i_monitor_entry(entry),
    .i_stack_ptr(SP_VAL),
    .o_return_from_interrupt_instr(run_pulse),
    .o_mem_addr(mem_addr),
    .o_mem_rd(mem_rd),
    .i_mem_rdata(mem_rdata),
    .o_mem_wr(mem_wr),
    .o_mem_wdata(mem_wdata)
  );
  mswcl_host u_mswcl_host (
    .i_core_clk(core_clk),
    .i_line(line),
    .o_pull_low(host_low)
  );
  function automatic logic [7:0] exp_rd(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h5A;
  endfunction
  task automatic check_frame(input string what, input logic [9:0] exp, input logic [9:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic do_reset(input logic div, input logic pll, input logic [3:0] mul, input int b);
    resetn <= 1'b0;
    div_pin <= div;
    pll_on <= pll;
    pll_mul <= mul;
    u_mswcl_host.bit_cyc = b;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  // Host waits for each echo before the next byte
  task automatic xfer(input logic [7:0] d);
    logic [9:0] f;
    u_mswcl_host.send_byte(d);
    u_mswcl_host.recv_frame(f);
    check_frame("echo", {1'b1, d, 1'b0}, f);
  endtask
  task automatic expect_byte(input logic [7:0] d);
    logic [9:0] f;
    u_mswcl_host.recv_frame(f);
    check_frame("result", {1'b1, d, 1'b0}, f);
  endtask
  task automatic sc_entry(input int b);
    int n;
    logic span_ok;
    int lows;
    n = 0;
    lows = 0;
    entry <= 1'b1;
    @(posedge core_clk);
    entry <= 1'b0;
    while (line !== 1'b0 && n < 30000) begin
      @(posedge core_clk);
      n++;
    end
    while (line === 1'b0 && lows < 30000) begin
      @(posedge core_clk);
      lows++;
    end
    span_ok = (lows >= 10 * b - 2) && (lows <= 10 * b + 2);
    check_word("break span ok", 16'h0001, {15'h0, span_ok});
  endtask
  task automatic sc_write();
    xfer(OP_WRITE);
    xfer(8'hFF);
    xfer(8'hFE);
    xfer(8'hA5);
    check_word("write addr", 16'hFFFE, wr_addr);
    check_word("write data", 16'h00A5, {8'h00, wr_data});
  endtask
  task automatic sc_indexed_read();
    xfer(OP_INDEXED_READ);
    expect_byte(exp_rd(16'hFFFF));
    expect_byte(exp_rd(16'h0000));
    check_word("index addr", 16'h0000, mem_addr);
    check_word("read strobes", 16'h0002, 16'(rd_count));
  endtask
  task automatic sc_indexed_write();
    xfer(OP_INDEXED_WRITE);
    xfer(8'h3C);
    check_word("indexed write addr", 16'h0001, wr_addr);
    check_word("indexed write data", 16'h003C, {8'h00, wr_data});
  endtask
  task automatic sc_stack_read();
    xfer(OP_STACK_READ);
    expect_byte(SP_VAL[15:8]);
    expect_byte(SP_VAL[7:0]);
  endtask
  task automatic sc_break();
    logic [9:0] f;
    int highs;
    highs = 0;
    u_mswcl_host.send_break();
    while (line === 1'b1 && highs < 5 * FAST) begin
      @(posedge core_clk);
      highs++;
    end
    check_word("break gap ok", 16'h0001, {15'h0, highs >= FAST && highs <= 3 * FAST});
    u_mswcl_host.recv_frame(f);
    check_frame("break echo", 10'h000, f);
  endtask
  task automatic sc_run();
    int lows;
    lows = 0;
    xfer(OP_RUN);
    repeat (4 * FAST) begin
      @(posedge core_clk);
      lows += (line === 1'b0) ? 1 : 0;
    end
    check_word("run pulses", 16'h0001, 16'(run_count));
    check_word("run result lows", 16'h0000, 16'(lows));
  endtask
  initial begin
    do_reset(1'b1, 1'b1, 4'h6, FAST);
    sc_entry(FAST);
    sc_write();
    sc_indexed_read();
    sc_indexed_write();
    sc_stack_read();
    sc_break();
    sc_run();
    // Multiplier must be ignored while the PLL is off
    do_reset(1'b0, 1'b0, 4'h3, SLOW);
    sc_entry(SLOW);
    complete_run();
  end
  initial begin
    repeat (130000) @(posedge core_clk);
    errors++;
    $display("Error watchdog expected done seen timeout");
    complete_run();
  end
endmodule // tb_top
